// ==== design/rpsf_top.sv ====
`timescale 1ns/1ps
// Function
// RULE1: Second byte low nibble holds receiving port
// RULE2: Clean flag set at start, cleared by collision
// RULE3: Without delimiter, clean window lasts whole reception
// RULE4: Collision flag set on any repeat collision
// RULE5: Alignment error flag set on misaligned frame
// RULE6: Checksum error flag set on bad CRC
// RULE7: Software ignores checksum flag when collision set
// RULE8: Collision timer top bits in third byte
// RULE9: Overlong lockup flag set on jabber
// RULE10: Elastic buffer fault flag on under/overflow
// RULE11: Lock loss flag when decoder loses lock
// RULE12: No-delimiter flag set when delimiter absent
// RULE13: No-delimiter flag ignores collisions entirely
// RULE14: Late-window collision flag on out-of-window collision
// RULE15: Runt flag set on short event
// RULE16: Collision timer counts bits, freezes at collision
// RULE17: Software trusts timer only with collision flag
// RULE18: Sixteen bit count of post-delimiter bytes
// RULE19: No delimiter: seven bit count from preamble
// RULE20: Software checks collision before trusting no-delimiter
// RULE21: Gap timer counts bits while not transmitting
// RULE22: Gap timer saturates at 255
// RULE23: Seven status bytes sent after each packet; a packet ending while a frame is being sent gets none
// RULE24: Status bytes reachable only via management bus
// RULE25: Per-packet state cleared at each new packet
// RULE26: Gap timer captured then cleared at transmit start
module rpsf_top (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_link,
  input  wire logic       rx_active,
  input  wire logic [3:0] receiving_port_index,
  input  wire logic       tx_active,
  input  wire logic       sfd_detect,
  input  wire logic       byte_tick,
  input  wire logic       collision,
  input  wire logic       align_error,
  input  wire logic       crc_error,
  input  wire logic       jabber_event,
  input  wire logic       elastic_event,
  input  wire logic       lock_loss_event,
  input  wire logic       late_collision,
  input  wire logic       short_event,
  output logic            mgmt_crs,
  output logic            mgmt_rxc,
  output logic            mgmt_rxd,
  output logic            mgmt_drive
);

  rpsf_sync_if #(.W(1)) rst_x ();
  rpsf_sync_if #(.W(1)) done_x ();

  logic                          rst_link;
  logic                          tx_q;
  logic                          pkt_start;
  logic                          pkt_end;
  logic                          end_q;
  logic                          tx_live;
  logic [3:0]                    port_idx;
  logic                          clean_receive_flag;
  logic                          coll_flag;
  logic                          framing_misalign_flag;
  logic                          checksum_fault_flag;
  logic                          overlong_lockup_flag;
  logic                          elastic_buffer_fault;
  logic                          decoder_lock_loss;
  logic                          late_coll_flag;
  logic                          runt_activity_flag;
  logic                          sfd_lat;
  logic                          clean_window_open;
  logic [rpsf_pkg::SHORT_W-1:0]  pre_cnt;
  logic [rpsf_pkg::RBY_W-1:0]    post_cnt;
  logic [rpsf_pkg::RBY_W-1:0]    repeat_byte_count;
  logic [rpsf_pkg::CBT_W-1:0]    collision_bit_timer;
  logic [7:0]                    gap_bit_timer;
  logic [7:0]                    gap_report;
  logic [7:0]                    byte_port;
  logic [7:0]                    byte_event;
  logic [rpsf_pkg::STATUS_BITS-1:0] snap;
  logic                          snap_toggle;
  logic                          done_q;
  logic                          cap;
  rpsf_pkg::rpsf_ser_state_t     state;
  logic [rpsf_pkg::STATUS_BITS-1:0] shift;
  logic [5:0]                    bit_idx;
  logic [2:0]                    half_cnt;

  // Reset reaches the link side through two flops
  assign rst_x.din = rst;
  rpsf_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk  (clk_link),
    .rst  (1'b0),
    .port (rst_x.sync)
  );
  assign rst_link = rst_x.dout;

  assign pkt_start = tx_active & ~tx_q;
  assign pkt_end   = ~tx_active & tx_q;
  // Events in the closing bit time still belong to the packet
  assign tx_live   = tx_active | tx_q;
  assign clean_window_open = ~sfd_lat | (post_cnt < rpsf_pkg::CLEAN_WINDOW_BYTES); // see RULE3

  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      tx_q  <= 1'b0;
      end_q <= 1'b0;
    end else begin
      tx_q  <= tx_active;
      end_q <= pkt_end;
    end
  end

  // Per-packet flags
  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      port_idx              <= 4'h0;
      clean_receive_flag    <= 1'b0;
      coll_flag             <= 1'b0;
      framing_misalign_flag <= 1'b0;
      checksum_fault_flag   <= 1'b0;
      overlong_lockup_flag  <= 1'b0;
      elastic_buffer_fault  <= 1'b0;
      decoder_lock_loss     <= 1'b0;
      late_coll_flag        <= 1'b0;
      runt_activity_flag    <= 1'b0;
    end else if (pkt_start) begin
      port_idx              <= receiving_port_index; // see RULE1
      clean_receive_flag    <= ~(collision & rx_active); // see RULE2
      coll_flag             <= collision; // see RULE25
      framing_misalign_flag <= align_error; // First-bit event wins over clear
      checksum_fault_flag   <= crc_error;
      overlong_lockup_flag  <= jabber_event;
      elastic_buffer_fault  <= elastic_event;
      decoder_lock_loss     <= lock_loss_event;
      late_coll_flag        <= late_collision;
      runt_activity_flag    <= short_event;
    end else begin
      if (collision && rx_active && clean_window_open) begin
        clean_receive_flag <= 1'b0; // see RULE2
      end
      if (tx_live && collision) begin
        coll_flag <= 1'b1; // see RULE4
      end
      if (tx_live && align_error) begin
        framing_misalign_flag <= 1'b1; // see RULE5
      end
      if (tx_live && crc_error) begin
        checksum_fault_flag <= 1'b1; // see RULE6
      end
      if (tx_live && jabber_event) begin
        overlong_lockup_flag <= 1'b1; // see RULE9
      end
      if (tx_live && elastic_event) begin
        elastic_buffer_fault <= 1'b1; // see RULE10
      end
      if (tx_live && lock_loss_event) begin
        decoder_lock_loss <= 1'b1; // see RULE11
      end
      if (tx_live && late_collision) begin
        late_coll_flag <= 1'b1; // see RULE14
      end
      if (tx_live && short_event) begin
        runt_activity_flag <= 1'b1; // see RULE15
      end
    end
  end

  // Byte counters; the short one saturates rather than wraps
  always_ff @(posedge clk_link) begin
    if (rst_link || pkt_start) begin
      sfd_lat  <= 1'b0; // see RULE25
      pre_cnt  <= '0;
      post_cnt <= '0;
    end else if (tx_active) begin
      if (sfd_detect) begin
        sfd_lat <= 1'b1;
      end
      if (byte_tick) begin
        if (sfd_lat) begin
          post_cnt <= post_cnt + 16'h0001; // see RULE18
        end
        if (pre_cnt != rpsf_pkg::SHORT_COUNT_MAX) begin
          pre_cnt <= pre_cnt + 7'h01; // see RULE19
        end
      end
    end
  end

  assign repeat_byte_count = sfd_lat ? post_cnt : {9'h000, pre_cnt}; // see RULE19
  // Collision bit timer
  always_ff @(posedge clk_link) begin
    if (rst_link || pkt_start) begin
      collision_bit_timer <= '0; // see RULE25
    end else if (tx_active && !coll_flag && !collision &&
                 collision_bit_timer != rpsf_pkg::CBT_MAX) begin
      collision_bit_timer <= collision_bit_timer + 10'h001; // see RULE16
    end
  end

  // Gap timer; value for this packet is frozen at transmit start
  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      gap_bit_timer <= 8'h00;
      gap_report    <= 8'h00;
    end else if (pkt_start) begin
      gap_report    <= gap_bit_timer; // see RULE26
      gap_bit_timer <= 8'h00;
    end else if (!tx_active && gap_bit_timer != rpsf_pkg::GAP_MAX) begin
      gap_bit_timer <= gap_bit_timer + 8'h01; // see RULE21, RULE22
    end
  end

  always_comb begin
    byte_port = 8'h00;
    byte_port[rpsf_pkg::PS1_PORT_LSB +: 4] = port_idx;
    byte_port[rpsf_pkg::PS1_CLEAN_BIT]     = clean_receive_flag;
    byte_port[rpsf_pkg::PS1_COLL_BIT]      = coll_flag;
    byte_port[rpsf_pkg::PS1_ALIGN_BIT]     = framing_misalign_flag;
    byte_port[rpsf_pkg::PS1_CRC_BIT]       = checksum_fault_flag;
  end

  always_comb begin
    byte_event = 8'h00;
    byte_event[rpsf_pkg::PS2_CBT_LSB +: 2] = collision_bit_timer[9:8]; // see RULE8
    byte_event[rpsf_pkg::PS2_JAB_BIT]      = overlong_lockup_flag;
    byte_event[rpsf_pkg::PS2_ELB_BIT]      = elastic_buffer_fault;
    byte_event[rpsf_pkg::PS2_LOCK_BIT]     = decoder_lock_loss;
    byte_event[rpsf_pkg::PS2_NO_DELIMITER_FLAG_BIT]     = ~sfd_lat; // see RULE12, RULE13
    byte_event[rpsf_pkg::PS2_OWC_BIT]      = late_coll_flag;
    byte_event[rpsf_pkg::PS2_SHORT_BIT]    = runt_activity_flag;
  end

  // Snapshot one bit time late so closing events count; it holds until
  // the next packet ends, so the system side may read it after the toggle
  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      snap        <= rpsf_pkg::SNAP_RESET;
      snap_toggle <= 1'b0;
    end else if (end_q) begin
      snap[rpsf_pkg::BYTE_FIRST*8  +: 8] <= rpsf_pkg::FIRST_BYTE_FILL;
      snap[rpsf_pkg::BYTE_PORT*8   +: 8] <= byte_port;
      snap[rpsf_pkg::BYTE_EVENT*8  +: 8] <= byte_event;
      snap[rpsf_pkg::BYTE_CBT_LO*8 +: 8] <= collision_bit_timer[7:0];
      snap[rpsf_pkg::BYTE_RBY_LO*8 +: 8] <= repeat_byte_count[7:0];
      snap[rpsf_pkg::BYTE_RBY_HI*8 +: 8] <= repeat_byte_count[15:8];
      snap[rpsf_pkg::BYTE_GAP*8    +: 8] <= gap_report;
      snap_toggle <= ~snap_toggle;
    end
  end

  // Packet-done toggle crosses to the system clock
  assign done_x.din = snap_toggle;
  rpsf_sync #(.W(1), .RST_VAL(1'b0)) u_done_sync (
    .clk  (clk_sys),
    .rst  (rst),
    .port (done_x.sync)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_x.dout;
    end
  end

  assign cap = done_x.dout ^ done_q;

  // Only path out is the management bus; a packet ending mid-frame is dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state      <= rpsf_pkg::RPSF_IDLE;
      shift      <= rpsf_pkg::SNAP_RESET;
      bit_idx    <= 6'h00;
      half_cnt   <= 3'h0;
      mgmt_crs   <= 1'b0;
      mgmt_rxc   <= 1'b0;
      mgmt_rxd   <= 1'b0;
      mgmt_drive <= 1'b0;
    end else begin
      case (state)
        rpsf_pkg::RPSF_IDLE: begin
          if (cap) begin
            state      <= rpsf_pkg::RPSF_SEND; // see RULE23, RULE24
            shift      <= snap;
            bit_idx    <= 6'h00;
            half_cnt   <= 3'h0;
            mgmt_crs   <= 1'b1;
            mgmt_drive <= 1'b1;
            mgmt_rxc   <= 1'b0;
            mgmt_rxd   <= snap[0];
          end
        end
        rpsf_pkg::RPSF_SEND: begin
          if (half_cnt != rpsf_pkg::HALF_LAST) begin
            half_cnt <= half_cnt + 3'h1;
          end else begin
            half_cnt <= 3'h0;
            if (!mgmt_rxc) begin
              mgmt_rxc <= 1'b1;
            end else begin
              mgmt_rxc <= 1'b0;
              if (bit_idx == rpsf_pkg::LAST_BIT) begin
                state      <= rpsf_pkg::RPSF_IDLE; // see RULE23
                mgmt_crs   <= 1'b0;
                mgmt_drive <= 1'b0;
                mgmt_rxd   <= 1'b0;
              end else begin
                bit_idx  <= bit_idx + 6'h01;
                shift    <= {1'b0, shift[rpsf_pkg::STATUS_BITS-1:1]};
                mgmt_rxd <= shift[1];
              end
            end
          end
        end
        default: begin
          state <= rpsf_pkg::RPSF_IDLE;
        end
      endcase
    end
  end

  // Checks on the link side
  a_clean_drop: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE2
    (!pkt_start && collision && rx_active && clean_window_open) |=> !clean_receive_flag)
    else $error("clean flag kept through early collision");
  a_clean_late: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE3
    (!pkt_start && sfd_lat && post_cnt > rpsf_pkg::CLEAN_WINDOW_BYTES && clean_receive_flag)
    |=> clean_receive_flag)
    else $error("clean flag dropped outside window");
  a_coll_set: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE4
    (tx_active && collision) |=> coll_flag)
    else $error("collision flag not set");
  a_cbt_count: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE16
    (tx_active && !pkt_start && !coll_flag && !collision && collision_bit_timer < 10'h3FE)
    |=> collision_bit_timer == $past(collision_bit_timer) + 10'h001)
    else $error("collision timer did not advance");
  a_cbt_freeze: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE16
    (coll_flag && !pkt_start) [*2] |-> $stable(collision_bit_timer))
    else $error("collision timer moved after collision");
  a_gap_capture: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE26
    pkt_start |=> (gap_bit_timer == 8'h00) && (gap_report == $past(gap_bit_timer)))
    else $error("gap timer not captured and cleared");
  a_gap_stick: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE22
    (gap_bit_timer == 8'hFF && !tx_active) |=> gap_bit_timer == 8'hFF)
    else $error("gap timer left saturation");
  a_short_cap: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE19
    (tx_active && !pkt_start && byte_tick && pre_cnt == 7'h7F) |=> pre_cnt == 7'h7F)
    else $error("short byte count wrapped");
  a_no_delimiter_flag_snap: assert property (@(posedge clk_link) disable iff (rst_link) // see RULE12
    end_q |=> snap[rpsf_pkg::BYTE_EVENT*8 + rpsf_pkg::PS2_NO_DELIMITER_FLAG_BIT] == !$past(sfd_lat))
    else $error("no-delimiter flag wrong in snapshot");
  // Checks on the management side
  sequence s_frame_open;
    (state == rpsf_pkg::RPSF_IDLE) && cap;
  endsequence
  sequence s_frame_body;
    mgmt_crs [*8];
  endsequence
  a_frame_len: assert property (@(posedge clk_sys) disable iff (rst) // see RULE23
    s_frame_open |=> s_frame_body ##[545:560] !mgmt_crs)
    else $error("status frame length wrong");
  a_rxd_edge: assert property (@(posedge clk_sys) disable iff (rst) // see RULE23
    (mgmt_crs && $changed(mgmt_rxd)) |-> !mgmt_rxc)
    else $error("data moved while clock high");
endmodule

// ==== design/rpsf_pkg.sv ====
package rpsf_pkg;

  // Status field geometry
  localparam int STATUS_BYTES = 7;
  localparam int STATUS_BITS  = STATUS_BYTES * 8;
  localparam int BYTE_FIRST   = 0;
  localparam int BYTE_PORT    = 1;
  localparam int BYTE_EVENT   = 2;
  localparam int BYTE_CBT_LO  = 3;
  localparam int BYTE_RBY_LO  = 4;
  localparam int BYTE_RBY_HI  = 5;
  localparam int BYTE_GAP     = 6;

  // Second status byte fields
  localparam int PS1_PORT_LSB  = 0;
  localparam int PS1_CLEAN_BIT = 4;
  localparam int PS1_COLL_BIT  = 5;
  localparam int PS1_ALIGN_BIT = 6;
  localparam int PS1_CRC_BIT   = 7;

  // Third status byte fields
  localparam int PS2_CBT_LSB   = 0;
  localparam int PS2_JAB_BIT   = 2;
  localparam int PS2_ELB_BIT   = 3;
  localparam int PS2_LOCK_BIT  = 4;
  localparam int PS2_NO_DELIMITER_FLAG_BIT  = 5;
  localparam int PS2_OWC_BIT   = 6;
  localparam int PS2_SHORT_BIT = 7;

  // Counter widths and limits
  localparam int          CBT_W              = 10;
  localparam int          RBY_W              = 16;
  localparam int          SHORT_W            = 7;
  localparam logic [9:0]  CBT_MAX            = 10'h3FF;
  localparam logic [6:0]  SHORT_COUNT_MAX    = 7'h7F;
  localparam logic [7:0]  GAP_MAX            = 8'hFF;
  localparam logic [15:0] CLEAN_WINDOW_BYTES = 16'h000D;

  // Reset and fill values
  localparam logic [7:0]  FIRST_BYTE_FILL = 8'h00;
  localparam logic [55:0] SNAP_RESET      = 56'h00000000000000;

  // Management bus bit timing
  localparam int         SYS_CLK_NS    = 10;
  localparam int         MGMT_BIT_NS   = 100;
  localparam int         MGMT_HALF_CYC = (MGMT_BIT_NS / SYS_CLK_NS) / 2;
  localparam logic [2:0] HALF_LAST     = 3'(MGMT_HALF_CYC - 1);
  localparam logic [5:0] LAST_BIT      = 6'(STATUS_BITS - 1);

  typedef enum logic [0:0] {
    RPSF_IDLE,
    RPSF_SEND
  } rpsf_ser_state_t;

endpackage

// ==== design/rpsf_sync_if.sv ====
`timescale 1ns/1ps
interface rpsf_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] din;
  logic [W-1:0] dout;

  modport sync (input din, output dout);
  modport user (output din, input dout);
endinterface

// ==== design/rpsf_sync.sv ====
`timescale 1ns/1ps
module rpsf_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic clk,
  input  wire logic rst,
  rpsf_sync_if.sync port
);
  // First stage feeds only the second
  logic [W-1:0] meta;
  logic [W-1:0] held;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RST_VAL;
      held <= RST_VAL;
    end else begin
      meta <= port.din;
      held <= meta;
    end
  end

  assign port.dout = held;
endmodule

// ==== test/rpsf_ctrl_model.sv ====
`timescale 1ns/1ps
module rpsf_ctrl_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        crs,
  input  wire logic        rxc,
  input  wire logic        rxd,
  input  wire logic        drive,
  output logic      [55:0] frame,
  output logic      [7:0]  nbits,
  output logic      [7:0]  frames
);
  logic        crs_w;
  logic        rxc_w;
  logic        rxc_q;
  logic        crs_q;
  logic [55:0] shift;
  logic [7:0]  cnt;

  // Released pins read low: no pull-up on this card
  assign crs_w = drive & crs;
  assign rxc_w = drive & rxc;

  // Raw bytes handed up; masking of flags is left to software
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxc_q  <= 1'b0;
      crs_q  <= 1'b0;
      shift  <= '0;
      cnt    <= 8'h00;
      frame  <= '0;
      nbits  <= 8'h00;
      frames <= 8'h00;
    end else begin
      rxc_q <= rxc_w;
      crs_q <= crs_w;
      if (crs_w && rxc_w && !rxc_q) begin
        shift <= {rxd, shift[55:1]};
        cnt   <= cnt + 8'h01;
      end
      if (crs_q && !crs_w) begin
        frame  <= shift;
        nbits  <= cnt;
        frames <= frames + 8'h01;
        cnt    <= 8'h00;
      end
    end
  end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        clk_sys;
  logic        rst;
  logic        clk_link;
  logic        rx_active;
  logic [3:0]  port_idx;
  logic        tx_active;
  logic        sfd_detect;
  logic        byte_tick;
  logic        collision;
  logic [6:0]  ev_in;
  logic        mgmt_crs;
  logic        mgmt_rxc;
  logic        mgmt_rxd;
  logic        mgmt_drive;
  logic [55:0] frame;
  logic [7:0]  nbits;
  logic [7:0]  frames;
  logic [7:0]  gap_m;
  int          failures;
  int          total_checks;
  bit          first;

  rpsf_top u_rpsf_top (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .clk_link             (clk_link),
    .rx_active            (rx_active),
    .receiving_port_index (port_idx),
    .tx_active            (tx_active),
    .sfd_detect           (sfd_detect),
    .byte_tick            (byte_tick),
    .collision            (collision),
    .align_error          (ev_in[0]),
    .crc_error            (ev_in[1]),
    .jabber_event         (ev_in[2]),
    .elastic_event        (ev_in[3]),
    .lock_loss_event      (ev_in[4]),
    .late_collision       (ev_in[5]),
    .short_event          (ev_in[6]),
    .mgmt_crs             (mgmt_crs),
    .mgmt_rxc             (mgmt_rxc),
    .mgmt_rxd             (mgmt_rxd),
    .mgmt_drive           (mgmt_drive)
  );

  rpsf_ctrl_model u_rpsf_ctrl_model (
    .clk_sys (clk_sys),
    .rst     (rst),
    .crs     (mgmt_crs),
    .rxc     (mgmt_rxc),
    .rxd     (mgmt_rxd),
    .drive   (mgmt_drive),
    .frame   (frame),
    .nbits   (nbits),
    .frames  (frames)
  );

  always #5 clk_sys = ~clk_sys;

  // Odd start offset keeps the link clock out of step with the system clock
  initial begin
    clk_link = 1'b0;
    #37;
    forever #80 clk_link = ~clk_link;
  end

  // Expected gap: idle bit times, saturating, zeroed while transmitting
  always @(posedge clk_link) begin
    if (tx_active) begin
      gap_m <= 8'h00;
    end else if (gap_m != 8'hFF) begin
      gap_m <= gap_m + 8'h01;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One repeated packet of n bytes; s is the delimiter byte (-1 none), c the collision bit
  task automatic pkt(input logic [3:0] port, input int n, input int s, input int c,
                     input logic [6:0] ev);
    int          si;
    int          post;
    int          post_c;
    int          cbt_e;
    int          cnt_e;
    int          w;
    logic [7:0]  gap_e;
    logic [7:0]  f0;
    logic        clean_e;
    logic [55:0] f;
    si = (s < 0) ? -1 : s * 8 + 3;
    post = 0;
    post_c = 0;
    f0 = frames;
    for (int i = 0; i < n * 8; i++) begin
      @(negedge clk_link);
      if (i == 0) begin
        gap_e = gap_m;
      end
      tx_active  = 1'b1;
      rx_active  = 1'b1;
      port_idx   = port;
      byte_tick  = (i % 8 == 7);
      sfd_detect = (i == si);
      collision  = (c > 0) && (i == c);
      ev_in      = (i == 4) ? ev : 7'h00;
      if (i == c) begin
        post_c = post;
      end
      if (i % 8 == 7 && si >= 0 && i > si) begin
        post++;
      end
    end
    @(negedge clk_link);
    {tx_active, rx_active, byte_tick, sfd_detect, collision, ev_in} = '0;
    cbt_e = (c > 0) ? c - 1 : ((n * 8 - 1 > 1023) ? 1023 : n * 8 - 1);
    cnt_e = (s < 0) ? ((n > 127) ? 127 : n) : n - s;
    clean_e = !(c > 0 && (s < 0 || post_c < 13));
    for (w = 0; w < 3000 && frames == f0; w++) begin
      @(posedge clk_sys);
    end
    if (frames == f0) begin
      failures++;
      $display("BAD frame arrival expected frame seen none");
      close_out();
    end
    @(negedge clk_sys);
    f = frame;
    check("frame bits", 16'(nbits), 16'(rpsf_pkg::STATUS_BITS));
    check("first byte", 16'(f[7:0]), 16'(rpsf_pkg::FIRST_BYTE_FILL));
    check("port", 16'(f[11:8]), 16'(port));
    check("clean", 16'(f[12]), 16'(clean_e));
    check("collision", 16'(f[13]), 16'(c > 0));
    check("align", 16'(f[14]), 16'(ev[0]));
    check("crc", 16'(f[15]), 16'(ev[1]));
    check("timer", 16'({f[17:16], f[31:24]}), 16'(cbt_e));
    check("jabber", 16'(f[18]), 16'(ev[2]));
    check("elastic", 16'(f[19]), 16'(ev[3]));
    check("lock", 16'(f[20]), 16'(ev[4]));
    check("no delimiter", 16'(f[21]), 16'(s < 0));
    check("late coll", 16'(f[22]), 16'(ev[5]));
    check("short", 16'(f[23]), 16'(ev[6]));
    check("byte count", f[47:32], 16'(cnt_e));
    if (!first) begin
      check("gap", 16'(f[55:48]), 16'(gap_e));
    end
    first = 1'b0;
    repeat (4) @(negedge clk_link);
  endtask

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {rx_active, tx_active, sfd_detect, byte_tick, collision} = '0;
    port_idx = 4'h0;
    ev_in = 7'h00;
    gap_m = 8'h00;
    failures = 0;
    total_checks = 0;
    first = 1'b1;
    // Longer than a bare 20 cycles: reset must reach the link side too
    repeat (60) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_link);
    pkt(4'h3, 20, 2, 0, 7'h00);
    for (int k = 0; k < 7; k++) begin
      pkt(4'(k + 5), 6, 1, 0, 7'(1 << k));
    end
    pkt(4'hA, 20, 1, 13 * 8 + 5, 7'h00);
    pkt(4'hB, 20, 1, 15 * 8 + 5, 7'h00);
    pkt(4'hC, 10, -1, 30, 7'h00);
    pkt(4'hD, 140, -1, 0, 7'h00);
    repeat (300) @(negedge clk_link);
    pkt(4'hF, 3, 0, 0, 7'h7F);
    close_out();
  end
endmodule
